// ---- include/ssd_regs.svh ----
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH

// Clock rate and timing figures
`define SSD_CLK_MHZ 200
`define SSD_SMPL_UNIT_US 50
`define SSD_WAKE_TIME_US 1000

// Serial frame layout: read/write bit, address, data
`define SSD_FRAME_RW_BIT 15
`define SSD_FRAME_ADDR_MSB 14
`define SSD_FRAME_ADDR_LSB 12
`define SSD_FRAME_WRITE 1'b0
`define SSD_ADDR_STATUS 3'h7
`define SSD_STAT_LAT_BIT 7

// Divider and counter constants
`define SSD_DIV_BASE_SHIFT 3'h2
`define SSD_CNT_MAX 4'h8

// Reset values
`define SSD_FLAG_RST 1'b0
`define SSD_BYTE_RST 8'h00

`endif

// ---- include/ssd_pkg.sv ----
package ssd_pkg;

  // Zero-current sampling sequence states
  typedef enum logic [1:0] {
    ssd_seq_idle = 2'h1,
    ssd_seq_sample = 2'h2
  } ssd_seq_state_t;

endpackage

// ---- core/ssd_stall_counter.sv ----
`timescale 1ns/1ps
`include "ssd_regs.svh"

module ssd_stall_counter (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Sample result
  input wire logic sample_valid,
  input wire logic below,
  input wire logic [1:0] stall_count_select,
  // Result
  output logic stall_hit,
  output logic [3:0] run_cnt_q
);

  logic [3:0] target;

  // Needed run length is 1, 2, 4 or 8 samples
  assign target = 4'h1 << stall_count_select;
  assign stall_hit = sample_valid && below
    && ((5'(run_cnt_q) + 5'h01) >= {1'b0, target}); // [R07]

  //////////////////////////////////////////////////////////////////
  // Consecutive low-sample count, saturating so it never wraps
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      run_cnt_q <= 4'h0; // [R25]
    end
    else if (clk_en && sample_valid)
    begin
      if (!below)
      begin
        run_cnt_q <= 4'h0; // [R25]
      end
      else if (run_cnt_q != `SSD_CNT_MAX)
      begin
        run_cnt_q <= run_cnt_q + 4'h1; // [R06]
      end
    end
  end

endmodule

// ---- core/ssd_zc_sequencer.sv ----
`timescale 1ns/1ps
`include "ssd_regs.svh"

module ssd_zc_sequencer #(
  parameter int unsigned UNIT_CYC = 10000,
  parameter int unsigned CNT_W = 20
) (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Step and configuration
  input wire logic zc_start,
  input wire logic drive_en,
  input wire logic a_was_pwm,
  input wire logic [2:0] zero_current_sample_time,
  // Bridge control
  output logic a_hold_low,
  output logic b_hold_low,
  output logic a_tristate,
  output logic b_tristate,
  // Sample timing
  output logic b_sensed_q,
  output logic sample_strobe_q,
  output logic busy
);

  ssd_pkg::ssd_seq_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] load;

  // Interval is (code + 1) sample-time units
  assign load = CNT_W'((32'(zero_current_sample_time) + 32'h1) * UNIT_CYC); // [R01]
  assign busy = (state_q == ssd_pkg::ssd_seq_sample);

  // The side that was PWMed is held low, the other floats
  assign a_hold_low = busy && b_sensed_q; // [R02]
  assign b_tristate = busy && b_sensed_q; // [R02]
  assign b_hold_low = busy && !b_sensed_q; // [R02]
  assign a_tristate = busy && !b_sensed_q; // [R02]

  //////////////////////////////////////////////////////////////////
  // Sequence; new steps during an interval are ignored so a short
  // step period never truncates a sample
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_q <= ssd_pkg::ssd_seq_idle;
      cnt_q <= '0;
      b_sensed_q <= `SSD_FLAG_RST;
    end
    else if (clk_en)
    begin
      unique case (state_q)
        ssd_pkg::ssd_seq_idle:
        begin
          if (zc_start && drive_en)
          begin
            state_q <= ssd_pkg::ssd_seq_sample; // [R01]
            cnt_q <= load;
            b_sensed_q <= a_was_pwm; // [R02]
          end
        end
        ssd_pkg::ssd_seq_sample:
        begin
          if (!drive_en || cnt_q == CNT_W'(1))
          begin
            state_q <= ssd_pkg::ssd_seq_idle; // [R13]
          end
          cnt_q <= cnt_q - CNT_W'(1);
        end
      endcase
    end
  end

  // Strobe marks the end of the interval
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sample_strobe_q <= `SSD_FLAG_RST;
    end
    else if (clk_en)
    begin
      sample_strobe_q <= busy && drive_en && cnt_q == CNT_W'(1); // [R03]
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_one_side_floats;
    busy |-> (a_tristate ^ b_tristate) && (a_hold_low == b_tristate);
  endproperty
  a_one_side_floats: assert property (p_one_side_floats) // [R02]
    else $error("bridge sides not opposite during sample");

  property p_strobe_ends;
    $past(clk_en) && sample_strobe_q |-> $past(busy) && !busy;
  endproperty
  a_strobe_ends: assert property (p_strobe_ends) // [R03]
    else $error("strobe not at interval end");

endmodule

// ---- core/ssd_stall_detect.sv ----
`timescale 1ns/1ps
`include "ssd_regs.svh"

// Function
// [R01] Zero-current step floats one side, grounds other
// [R02] PWMed side held low, other side floats
// [R03] Back-EMF sampled when sample interval ends
// [R04] Sample divided by 4, 8, 16 or 32
// [R05] Mode select low means internal stall mode
// [R06] Sample below threshold counts as stall sample
// [R07] Stall waits for selected consecutive count
// [R08] Stall drives pin low, sets both flags
// [R09] Clean step releases pin, clears stall flag
// [R10] Latched flag held until software clears it
// [R11] Full-step mode disables stall detection
// [R12] External mode flags each ready sample
// [R13] Sample survives steps shorter than interval
// [R14] Software clear drops external flag and pin
// [R15] Next zero-current step auto-clears external latch
// [R16] Controller keeps step period above interval
// [R17] Reset clears logic, disables drive, ignores inputs
// [R18] Supply undervoltage acts as full reset
// [R19] Controller waits about 1 ms after reset
// [R20] Sleep stops drive and analog, keeps digital
// [R21] Reset pin ignored while sleeping
// [R22] Controller waits about 1 ms after sleep
// [R23] Frames are rw bit, address, data
// [R24] Step ignored during any fault
// [R25] Run counter clears on good sample, reset

module ssd_stall_detect #(
  parameter int unsigned SMPL_UNIT_CYC = `SSD_SMPL_UNIT_US * `SSD_CLK_MHZ,
  parameter int unsigned WAKE_CYC = `SSD_WAKE_TIME_US * `SSD_CLK_MHZ
) (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Device pins and supply status
  input wire logic reset_in,
  input wire logic sleep_low_in,
  input wire logic motor_supply_uv,
  input wire logic fault_active,
  input wire logic step_in,
  // Indexer status
  input wire logic zc_step_start,
  input wire logic a_was_pwm,
  input wire logic full_step_mode,
  // Configuration
  input wire logic external_stall_select,
  input wire logic [2:0] zero_current_sample_time,
  input wire logic [1:0] back_emf_divider_select,
  input wire logic [1:0] stall_count_select,
  input wire logic [7:0] stall_threshold,
  // Digitised phase voltages
  input wire logic [7:0] back_emf_hold_out_a,
  input wire logic [7:0] back_emf_hold_out_b,
  // Serial frame
  input wire logic frame_valid,
  input wire logic [15:0] frame_data,
  // Bridge control
  output logic a_hold_low,
  output logic b_hold_low,
  output logic a_tristate,
  output logic b_tristate,
  // Stall outputs
  output logic stall_or_sample_ready_n,
  output logic [7:0] back_emf_hold_out,
  output logic stall_flag,
  output logic stall_flag_latched,
  output logic stall_flag_ext,
  output logic stall_flag_latched_ext,
  // Power and gating
  output logic core_reset,
  output logic power_stage_en,
  output logic analog_en,
  output logic step_accept,
  output logic device_ready
);

  logic core_rst_q, rst_int, pin_rst, pwr_q, analog_q;
  logic [17:0] wake_cnt_q;
  logic b_sensed_q, strobe_q, smp_ok, stall_hit, below, lat_clr;
  logic [7:0] back_emf_hold_out_sel, back_emf_hold_out_div, hold_q;
  logic flag_q, lat_q, flag_ext_q, lat_ext_q;
  logic [3:0] run_cnt;

  //////////////////////////////////////////////////////////////////
  // Reset and sleep gating

  // Pin reset only acts out of sleep; undervoltage always acts
  assign pin_rst = (reset_in && sleep_low_in) // [R21]
    || motor_supply_uv; // [R18]

  // Registered reset request, one enabled edge behind the pins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      core_rst_q <= `SSD_FLAG_RST;
    else if (clk_en)
      core_rst_q <= pin_rst;
  end

  assign rst_int = sys_rst || core_rst_q; // [R17]
  assign core_reset = rst_int;

  // Drive needs awake, out of reset and no fault
  always_ff @(posedge clk)
  begin
    if (rst_int)
    begin
      pwr_q <= `SSD_FLAG_RST; // [R17]
      analog_q <= `SSD_FLAG_RST;
    end
    else if (clk_en)
    begin
      // Drops on the same edge that takes a reset, so drive never overlaps it
      pwr_q <= sleep_low_in && !fault_active && !pin_rst; // [R20] [R17]
      analog_q <= sleep_low_in; // [R20]
    end
  end

  assign power_stage_en = pwr_q;
  assign analog_en = analog_q;

  // Steps pass only with drive up and no fault
  assign step_accept = step_in && pwr_q && !fault_active && !rst_int; // [R24]

  // Settling timer; ready flags when the controller may step
  always_ff @(posedge clk)
  begin
    if (rst_int)
      wake_cnt_q <= 18'(WAKE_CYC); // [R19]
    else if (clk_en)
    begin
      if (!sleep_low_in)
        wake_cnt_q <= 18'(WAKE_CYC); // [R22]
      else if (wake_cnt_q != 18'h0_0000)
        wake_cnt_q <= wake_cnt_q - 18'h0_0001;
    end
  end

  assign device_ready = (wake_cnt_q == 18'h0_0000);

  //////////////////////////////////////////////////////////////////
  // Sampling sequence and run counter

  ssd_zc_sequencer #(
    .UNIT_CYC(SMPL_UNIT_CYC),
    .CNT_W(20)
  ) u_seq (
    .clk(clk), .sys_rst(rst_int), .clk_en(clk_en), .zc_start(zc_step_start),
    .drive_en(pwr_q), .a_was_pwm(a_was_pwm),
    .zero_current_sample_time(zero_current_sample_time),
    .a_hold_low(a_hold_low), .b_hold_low(b_hold_low), .a_tristate(a_tristate),
    .b_tristate(b_tristate), .b_sensed_q(b_sensed_q), .sample_strobe_q(strobe_q), .busy()
  );

  // Full-step mode gates off all stall reporting
  assign smp_ok = strobe_q && !full_step_mode; // [R11]

  // Read the floating side, then scale down
  assign back_emf_hold_out_sel = b_sensed_q ? back_emf_hold_out_b : back_emf_hold_out_a; // [R03]
  assign back_emf_hold_out_div = back_emf_hold_out_sel >> (`SSD_DIV_BASE_SHIFT + {1'b0, back_emf_divider_select}); // [R04]
  assign below = back_emf_hold_out_div < stall_threshold; // [R06]

  ssd_stall_counter u_cnt (
    .clk(clk), .sys_rst(rst_int), .clk_en(clk_en),
    .sample_valid(smp_ok && !external_stall_select), .below(below),
    .stall_count_select(stall_count_select), .stall_hit(stall_hit), .run_cnt_q(run_cnt)
  );

  // Held output updates only at interval end, so it stays put
  // while the controller converts it
  always_ff @(posedge clk)
  begin
    if (rst_int)
      hold_q <= `SSD_BYTE_RST;
    else if (clk_en && strobe_q)
      hold_q <= back_emf_hold_out_div; // [R04]
  end

  assign back_emf_hold_out = hold_q;

  //////////////////////////////////////////////////////////////////
  // Status flags

  // Write of 0 to the latch bit of the status address; frames are
  // dropped under reset
  assign lat_clr = frame_valid && !rst_int
    && frame_data[`SSD_FRAME_RW_BIT] == `SSD_FRAME_WRITE
    && frame_data[`SSD_FRAME_ADDR_MSB:`SSD_FRAME_ADDR_LSB] == `SSD_ADDR_STATUS
    && !frame_data[`SSD_STAT_LAT_BIT]; // [R23]

  // Internal mode: each gated sample decides the live flag
  always_ff @(posedge clk)
  begin
    if (rst_int)
    begin
      flag_q <= `SSD_FLAG_RST;
      lat_q <= `SSD_FLAG_RST;
    end
    else if (clk_en)
    begin
      if (smp_ok && !external_stall_select) // [R05]
        flag_q <= stall_hit; // [R08] [R09]
      if (smp_ok && !external_stall_select && stall_hit)
        lat_q <= 1'b1; // [R08]
      else if (lat_clr)
        lat_q <= 1'b0; // [R10]
    end
  end

  // External mode: a new sample beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst_int)
    begin
      flag_ext_q <= `SSD_FLAG_RST;
      lat_ext_q <= `SSD_FLAG_RST;
    end
    else if (clk_en)
    begin
      if (smp_ok && external_stall_select)
      begin
        flag_ext_q <= 1'b1; // [R12]
        lat_ext_q <= 1'b1; // [R12]
      end
      else if (lat_clr || zc_step_start)
      begin
        flag_ext_q <= 1'b0; // [R14] [R15]
        lat_ext_q <= 1'b0; // [R15]
      end
    end
  end

  assign stall_flag = flag_q;
  assign stall_flag_latched = lat_q;
  assign stall_flag_ext = flag_ext_q;
  assign stall_flag_latched_ext = lat_ext_q;

  // Pin shows whichever flag the mode selects
  assign stall_or_sample_ready_n = external_stall_select ? !flag_ext_q : !flag_q; // [R05]

  //////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst_int);

  property p_stall_sets;
    clk_en && smp_ok && !external_stall_select && stall_hit
      |=> !stall_or_sample_ready_n || external_stall_select ##0 stall_flag && stall_flag_latched;
  endproperty
  a_stall_sets: assert property (p_stall_sets) // [R08]
    else $error("stall did not set flags");

  property p_clean_clears;
    clk_en && smp_ok && !external_stall_select && !stall_hit |=> !stall_flag;
  endproperty
  a_clean_clears: assert property (p_clean_clears) // [R09]
    else $error("clean sample left stall flag set");

  property p_latch_holds;
    clk_en && stall_flag_latched && !lat_clr |=> stall_flag_latched;
  endproperty
  a_latch_holds: assert property (p_latch_holds) // [R10]
    else $error("latched flag dropped without clear");

  property p_full_step_quiet;
    clk_en && full_step_mode && !stall_flag && !stall_flag_ext && !zc_step_start
      |=> !stall_flag && !stall_flag_ext;
  endproperty
  a_full_step_quiet: assert property (p_full_step_quiet) // [R11]
    else $error("flag raised in full-step mode");

  property p_ext_ready;
    clk_en && smp_ok && external_stall_select
      |=> stall_flag_ext && stall_flag_latched_ext ##0
        (!stall_or_sample_ready_n || !external_stall_select);
  endproperty
  a_ext_ready: assert property (p_ext_ready) // [R12]
    else $error("external sample not flagged");

  property p_ext_clear;
    clk_en && lat_clr && !smp_ok |=> !stall_flag_ext && !stall_flag_latched_ext;
  endproperty
  a_ext_clear: assert property (p_ext_clear) // [R14]
    else $error("software clear ignored");

  property p_ext_auto;
    clk_en && zc_step_start && !smp_ok |=> !stall_flag_latched_ext;
  endproperty
  a_ext_auto: assert property (p_ext_auto) // [R15]
    else $error("external latch not auto-cleared");

  property p_hold_value;
    clk_en && strobe_q |=> back_emf_hold_out == $past(back_emf_hold_out_div);
  endproperty
  a_hold_value: assert property (p_hold_value) // [R04]
    else $error("held value not the divided sample");

  property p_reset_off;
    @(posedge clk) disable iff (sys_rst)
      core_rst_q |-> !power_stage_en && !step_accept;
  endproperty
  a_reset_off: assert property (p_reset_off) // [R17]
    else $error("drive on during reset");

  property p_sleep_masks_reset;
    @(posedge clk) disable iff (sys_rst)
      clk_en && !sleep_low_in && !motor_supply_uv |=> !core_rst_q;
  endproperty
  a_sleep_masks_reset: assert property (p_sleep_masks_reset) // [R21]
    else $error("reset acted during sleep");

  property p_sleep_off;
    !sleep_low_in ##1 !sleep_low_in |-> !power_stage_en || !clk_en;
  endproperty
  a_sleep_off: assert property (p_sleep_off) // [R20]
    else $error("drive on in sleep");

  property p_fault_step;
    fault_active |-> !step_accept;
  endproperty
  a_fault_step: assert property (p_fault_step) // [R24]
    else $error("step passed during fault");

  c_stall: cover property (clk_en && smp_ok && stall_hit && !external_stall_select);
  c_ext_sample: cover property (clk_en && smp_ok && external_stall_select);
  c_sw_clear: cover property (stall_flag_latched_ext && lat_clr);
  c_count_eight: cover property (run_cnt == `SSD_CNT_MAX);

endmodule

// ---- verification/ssd_mcu_model.sv ----
`timescale 1ns/1ps

// Controller on the far side: reads the held voltage when the pin drops
module ssd_mcu_model (
  // Clock
  input wire logic clk,
  // Device outputs watched
  input wire logic stall_or_sample_ready_n,
  input wire logic [7:0] back_emf_hold_out,
  // Behaviour knobs from the bench
  input wire logic auto_en,
  input wire logic wrong_en,
  input wire logic kick,
  input wire logic [7:0] lag,
  // Serial frame towards the device
  output logic frame_valid,
  output logic [15:0] frame_data,
  output logic [7:0] seen_hold
);
  logic [7:0] wait_n_q;

  initial
  begin
    frame_valid = 1'b0;
    frame_data = 16'hffff;
    seen_hold = 8'h00;
    wait_n_q = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle data flips every cycle, so a decoder that ignores valid is caught.
  // A slow lag mimics a busy controller; wrong_en sends a read, not a write.
  always @(posedge clk)
  begin
    frame_valid <= 1'b0;
    frame_data <= ~frame_data;
    if (kick || (auto_en && !stall_or_sample_ready_n && wait_n_q == lag))
    begin
      frame_valid <= 1'b1;
      frame_data <= {wrong_en, 3'h7, 12'h000};
      seen_hold <= back_emf_hold_out;
      wait_n_q <= 8'h00;
    end
    else
      wait_n_q <= (auto_en && !stall_or_sample_ready_n) ? wait_n_q + 8'h01 : 8'h00;
  end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
  localparam int UNIT = 4;
  localparam int WAKE = 8;
  logic clk, sys_rst, reset_in, sleep_low_in, motor_supply_uv, fault_active, step_in;
  logic zc_step_start, a_was_pwm, full_step_mode, external_stall_select;
  logic [2:0] zero_current_sample_time;
  logic [1:0] back_emf_divider_select, stall_count_select;
  logic [7:0] stall_threshold, back_emf_hold_out_a, back_emf_hold_out_b, lag, seen_hold, back_emf_hold_out, v;
  logic frame_valid, auto_en, wrong_en, kick, stall_or_sample_ready_n, clk_en;
  logic [15:0] frame_data;
  logic a_hold_low, b_hold_low, a_tristate, b_tristate;
  logic stall_flag, stall_flag_latched, stall_flag_ext, stall_flag_latched_ext;
  logic core_reset, power_stage_en, analog_en, step_accept, device_ready;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 13;
  logic [8:0] exp_q[$];

  ssd_stall_detect #(.SMPL_UNIT_CYC(UNIT), .WAKE_CYC(WAKE)) ssd_stall_detect_i (
    .clk, .sys_rst, .clk_en, .reset_in, .sleep_low_in, .motor_supply_uv,
    .fault_active, .step_in, .zc_step_start(zc_step_start), .a_was_pwm, .full_step_mode,
    .external_stall_select, .zero_current_sample_time, .back_emf_divider_select,
    .stall_count_select, .stall_threshold, .back_emf_hold_out_a, .back_emf_hold_out_b, .frame_valid, .frame_data,
    .a_hold_low, .b_hold_low, .a_tristate, .b_tristate, .stall_or_sample_ready_n,
    .back_emf_hold_out, .stall_flag, .stall_flag_latched, .stall_flag_ext,
    .stall_flag_latched_ext, .core_reset, .power_stage_en, .analog_en, .step_accept,
    .device_ready);

  ssd_mcu_model ssd_mcu_model_i (.clk, .stall_or_sample_ready_n, .back_emf_hold_out,
    .auto_en, .wrong_en, .kick, .lag, .frame_valid, .frame_data, .seen_hold);

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the ceiling is far above the planned run
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait for the settle timer, then device_ready must be set
  task automatic wait_ready();
    int n;
    n = 0;
    while (device_ready !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge clk);
    end
    ticks(2);
    chk(16'(device_ready), 16'h0001);
  endtask

  // One zero-current step; the unsensed phase carries the inverse value
  task automatic zc_step(input logic pwm, input logic [7:0] sensed, input logic [2:0] code,
                         input logic flag, input logic dbl, input logic auto_chk);
    int n;
    exp_q.push_back({8'(sensed >> (3'd2 + 3'(back_emf_divider_select))), flag});
    a_was_pwm = pwm;
    back_emf_hold_out_a = pwm ? ~sensed : sensed;
    back_emf_hold_out_b = pwm ? sensed : ~sensed;
    zero_current_sample_time = code;
    zc_step_start = 1'b1;
    @(negedge clk);
    zc_step_start = 1'b0;
    chk(16'({a_hold_low, b_tristate, b_hold_low, a_tristate}), 16'({pwm, pwm, !pwm, !pwm}));
    if (auto_chk)
      chk(16'({stall_flag_latched_ext, stall_or_sample_ready_n}), 16'h0001);
    n = 0;
    while ((a_tristate || b_tristate) && n < 300)
    begin
      n++;
      zc_step_start = dbl && n == 2;
      @(negedge clk);
    end
    zc_step_start = 1'b0;
    chk(16'(n), 16'((int'(code) + 1) * UNIT));
    ticks(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: one cycle after the bridges release, the oldest note is due
  initial
  begin : watch
    logic was;
    logic pend;
    logic [8:0] note;
    was = 1'b0;
    pend = 1'b0;
    forever
    begin
      @(negedge clk);
      if (pend && exp_q.size() > 0)
      begin
        note = exp_q.pop_front();
        chk(16'(back_emf_hold_out), 16'(note[8:1]));
        chk(16'(external_stall_select ? stall_flag_ext : stall_flag), 16'(note[0]));
        chk(16'(stall_or_sample_ready_n), 16'(!note[0]));
      end
      pend = was && !(a_tristate || b_tristate);
      was = a_tristate || b_tristate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: power gating first, then both stall modes
  initial
  begin : main
    int s;
    int k;
    {sys_rst, sleep_low_in, clk_en} = 3'b111;
    {reset_in, motor_supply_uv, fault_active, step_in, zc_step_start, a_was_pwm} = 6'h00;
    {full_step_mode, external_stall_select, auto_en, wrong_en, kick} = 5'h00;
    {zero_current_sample_time, back_emf_divider_select, stall_count_select} = 7'h00;
    {stall_threshold, back_emf_hold_out_a, back_emf_hold_out_b, lag} = 32'h0000_0000;
    repeat (4) @(negedge clk);
    chk(16'({core_reset, power_stage_en, stall_or_sample_ready_n, stall_flag_latched}), 16'h000a);
    sys_rst = 1'b0;
    wait_ready();
    for (s = 0; s < 2; s++)
    begin
      reset_in = (s == 0);
      motor_supply_uv = (s == 1);
      step_in = 1'b1;
      ticks(3);
      chk(16'({core_reset, power_stage_en, step_accept}), 16'h0004);
      {reset_in, motor_supply_uv} = 2'b00;
      wait_ready();
      chk(16'({core_reset, step_accept}), 16'h0001);
    end
    sleep_low_in = 1'b0;
    ticks(3);
    chk(16'({analog_en, power_stage_en, core_reset}), 16'h0000);
    reset_in = 1'b1;
    ticks(3);
    chk(16'(core_reset), 16'h0000);
    sleep_low_in = 1'b1;
    ticks(3);
    chk(16'(core_reset), 16'h0001);
    reset_in = 1'b0;
    wait_ready();
    chk(16'(analog_en), 16'h0001);
    fault_active = 1'b1;
    ticks(3);
    chk(16'({step_accept, power_stage_en}), 16'h0000);
    fault_active = 1'b0;
    wait_ready();
    // Internal mode: every count and divider, threshold met exactly first
    for (s = 0; s < 4; s++)
    begin
      {stall_count_select, back_emf_divider_select} = {2'(s), 2'(s)};
      v = 8'($random(seed));
      stall_threshold = v >> (2 + s);
      zc_step(v[0], v, 3'(s), 1'b0, 1'b0, 1'b0);
      for (k = 1; k <= (1 << s) + 1; k++)
      begin
        v = 8'($random(seed));
        stall_threshold = (v >> (2 + s)) + 8'h01;
        zc_step(v[1], v, 3'(s), k >= (1 << s), 1'b0, 1'b0);
      end
      chk(16'({stall_flag_latched, stall_or_sample_ready_n}), 16'h0002);
      stall_threshold = 8'h00;
      zc_step(v[2], v, 3'h7, 1'b0, 1'b0, 1'b0);
      chk(16'(stall_flag_latched), 16'h0001);
      kick = 1'b1;
      @(negedge clk);
      kick = 1'b0;
      ticks(2);
      chk(16'(stall_flag_latched), 16'h0000);
    end
    // Full step hides stalls; a reset in mid-run clears the run count
    {full_step_mode, stall_count_select, stall_threshold} = {1'b1, 2'h0, 8'hff};
    zc_step(1'b1, 8'h10, 3'h0, 1'b0, 1'b0, 1'b0);
    chk(16'(stall_flag_latched), 16'h0000);
    {full_step_mode, stall_count_select} = 3'b001;
    zc_step(1'b0, 8'h10, 3'h0, 1'b0, 1'b0, 1'b0);
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    wait_ready();
    zc_step(1'b0, 8'h10, 3'h0, 1'b0, 1'b0, 1'b0);
    // External mode: fast and slow controller, a step inside the interval
    {external_stall_select, auto_en} = 2'b11;
    for (k = 0; k < 4; k++)
    begin
      lag = (k % 2) ? 8'd40 : 8'd2;
      v = 8'($random(seed));
      back_emf_divider_select = v[7:6];
      zc_step(v[0], v, 3'(k + 4), 1'b1, k == 1, 1'b0);
      ticks(50);
      chk(16'({stall_flag_ext, stall_flag_latched_ext, stall_or_sample_ready_n}), 16'h0001);
      chk(16'(seen_hold), 16'(v >> (2 + v[7:6])));
    end
    {wrong_en, lag} = {1'b1, 8'd2};
    zc_step(1'b1, 8'h80, 3'h0, 1'b1, 1'b0, 1'b0);
    ticks(20);
    chk(16'(stall_flag_latched_ext), 16'h0001);
    {auto_en, wrong_en} = 2'b00;
    zc_step(1'b0, 8'h44, 3'h1, 1'b1, 1'b0, 1'b1);
    // A frame while the clock enable is low must leave the latch alone
    clk_en = 1'b0;
    kick = 1'b1;
    @(negedge clk);
    kick = 1'b0;
    ticks(2);
    chk(16'(stall_flag_latched_ext), 16'h0001);
    clk_en = 1'b1;
    kick = 1'b1;
    @(negedge clk);
    kick = 1'b0;
    ticks(2);
    chk(16'({stall_flag_ext, stall_or_sample_ready_n}), 16'h0001);
    test_done();
  end
endmodule
